// File: core/ilrcs_pkg.sv
// ilrcs_pkg: constants for the inter-level register and compare-skip core.
// assumes a 16-bit word, eight register codes and sixteen program levels.
package ilrcs_pkg;
  localparam int          WORD_W        = 16;
  localparam int          LEVELS        = 16;
  localparam int          LEVEL_W       = 4;
  localparam int          REG_W         = 3;
  localparam int          NREGS         = 8;
  // opcode compare masks and base codes (octal 153600, 153400, 140000)
  localparam logic [15:0] READ_MASK     = 16'hFF80;
  localparam logic [15:0] READ_BASE     = 16'hD780;
  localparam logic [15:0] WRITE_BASE    = 16'hD700;
  localparam logic [15:0] SKIP_MASK     = 16'hF8C0;
  localparam logic [15:0] SKIP_BASE     = 16'hC000;
  // field positions
  localparam int          DR_LSB        = 0;
  localparam int          SR_LSB        = 3;
  localparam int          LEVEL_LSB     = 3;
  localparam int          COND_LSB      = 8;
  // register codes: 0 is status in inter-level ops, 2 is program counter
  localparam logic [2:0]  REG_STATUS    = 3'h0;
  localparam logic [2:0]  REG_PC        = 3'h2;
  localparam logic [2:0]  REG_A         = 3'h5;
  // status bits 1-7 carried across
  localparam int          STS_LO        = 1;
  localparam int          STS_HI        = 7;
  localparam logic [15:0] STS_MASK      = 16'h00FE;
  localparam logic [15:0] RESET_WORD    = 16'h0000;
  localparam logic [3:0]  RESET_LEVEL   = 4'h0;
  typedef enum logic [2:0] {
    EQUAL_COND                     = 3'h0,
    SIGNED_GE_PLAIN_COND           = 3'h1,
    SIGNED_GE_OVERFLOW_AWARE_COND  = 3'h2,
    UNSIGNED_GE_COND               = 3'h3,
    NOT_EQUAL_COND                 = 3'h4,
    SIGNED_LT_PLAIN_COND           = 3'h5,
    SIGNED_LT_OVERFLOW_AWARE_COND  = 3'h6,
    UNSIGNED_LT_COND               = 3'h7
  } ilrcs_cond_t;
endpackage

// File: core/ilrcs_cmp.sv
// ilrcs_cmp: combinational compare of dest minus source, condition result.
// assumes both operands come from flip-flops on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ilrcs_cmp (
  // operands
  input  wire logic [15:0] dest_val,
  input  wire logic [15:0] src_val,
  input  wire logic [2:0]  cond,
  // result
  output logic             cond_true
);
  logic [16:0] diff;
  logic        s_ind;
  logic        z_ind;
  logic        c_ind;
  logic        o_ind;
  always_comb begin
    diff  = {1'b0, dest_val} + {1'b0, ~src_val} + 17'h00001;
    s_ind = diff[15];
    z_ind = (diff[15:0] == 16'h0000);
    c_ind = diff[16];
    o_ind = (dest_val[15] != src_val[15]) && (diff[15] != dest_val[15]);
  end
  always_comb begin
    unique case (ilrcs_pkg::ilrcs_cond_t'(cond))
      ilrcs_pkg::EQUAL_COND:                    cond_true = z_ind;
      ilrcs_pkg::NOT_EQUAL_COND:                cond_true = !z_ind;
      ilrcs_pkg::SIGNED_GE_PLAIN_COND:          cond_true = !s_ind;
      ilrcs_pkg::SIGNED_LT_PLAIN_COND:          cond_true = s_ind;
      ilrcs_pkg::SIGNED_GE_OVERFLOW_AWARE_COND: cond_true = !(s_ind ^ o_ind);
      ilrcs_pkg::SIGNED_LT_OVERFLOW_AWARE_COND: cond_true = s_ind ^ o_ind;
      ilrcs_pkg::UNSIGNED_GE_COND:              cond_true = c_ind;
      ilrcs_pkg::UNSIGNED_LT_COND:              cond_true = !c_ind;
    endcase
  end
endmodule
`default_nettype wire

// File: core/ilrcs_core.sv
// ilrcs_core: banked register file with inter-level read/write and
// compare-skip execution. assumes one instruction offered per valid pulse.
// How it works
// - sixteen full register and status sets, one per program level
// - bits 0-2 pick the register, bits 3-6 pick the level
// - inter-level read copies chosen level's register into current A
// - read of code zero puts status into A bits 1-7, rest cleared
// - both inter-level instructions are privileged
// - inter-level write copies current A into chosen level's register
// - write to own level's program counter changes nothing
// - write of code zero puts A bits 1-7 into chosen level status
// - compare-skip decodes only with bits 6 and 7 both zero
// - compare computes dest minus source giving s, z, c, o
// - true condition skips the next instruction, else continue
// - code 000 true when equal, 100 true when unequal
// - codes 001 and 101 test sign alone
// - codes 010 and 110 test sign xor overflow
`timescale 1ns/1ps
`default_nettype none
module ilrcs_core (
  // clock, reset, enable
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  // instruction
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic        privileged,
  input  wire logic [3:0]  current_level,
  // register file access from the rest of the core
  input  wire logic        ext_wr_en,
  input  wire logic [3:0]  ext_wr_level,
  input  wire logic [2:0]  ext_wr_reg,
  input  wire logic [15:0] ext_wr_data,
  input  wire logic [3:0]  ext_rd_level,
  input  wire logic [2:0]  ext_rd_reg,
  output logic [15:0]      ext_rd_data,
  // results
  output logic             interlevel_read_instr,
  output logic             interlevel_write_instr,
  output logic             compare_skip_instr,
  output logic             skip_next,
  output logic             priv_violation,
  output logic             done
);
  // one bank per level; code 0 of each bank holds its status
  logic [15:0] bank_reg [ilrcs_pkg::LEVELS][ilrcs_pkg::NREGS];
  logic        is_read;
  logic        is_write;
  logic        is_skip;
  logic [2:0]  dest_reg_field;
  logic [2:0]  source_reg_field;
  logic [3:0]  sel_level;
  logic [2:0]  cond_field;
  logic        cond_true;
  logic        wr_en;
  logic [3:0]  wr_level;
  logic [2:0]  wr_reg;
  logic [15:0] wr_data;
  logic [15:0] sel_val;

  assign dest_reg_field   = instr_word[ilrcs_pkg::DR_LSB +: 3];
  assign source_reg_field = instr_word[ilrcs_pkg::SR_LSB +: 3];
  assign sel_level        = instr_word[ilrcs_pkg::LEVEL_LSB +: 4];
  assign cond_field       = instr_word[ilrcs_pkg::COND_LSB +: 3];

  assign is_read  = instr_valid && ((instr_word & ilrcs_pkg::READ_MASK)
                    == ilrcs_pkg::READ_BASE);
  assign is_write = instr_valid && ((instr_word & ilrcs_pkg::READ_MASK)
                    == ilrcs_pkg::WRITE_BASE);
  // bits 6 and 7 must be zero
  assign is_skip  = instr_valid && ((instr_word & ilrcs_pkg::SKIP_MASK)
                    == ilrcs_pkg::SKIP_BASE);

  assign sel_val = bank_reg[sel_level][dest_reg_field];

  ilrcs_cmp u_cmp (
    .dest_val  (bank_reg[current_level][dest_reg_field]),
    .src_val   (bank_reg[current_level][source_reg_field]),
    .cond      (cond_field),
    .cond_true (cond_true)
  );

  // single write port: instruction writes take priority over external ones
  always_comb begin
    wr_en    = 1'b0;
    wr_level = current_level;
    wr_reg   = ilrcs_pkg::REG_A;
    wr_data  = ilrcs_pkg::RESET_WORD;
    // privilege gates both; no change when unprivileged
    if (is_read && privileged) begin
      wr_en = 1'b1;
      if (dest_reg_field == ilrcs_pkg::REG_STATUS) begin
        wr_data = sel_val & ilrcs_pkg::STS_MASK;
      end else begin
        wr_data = sel_val;
      end
    end else if (is_write && privileged) begin
      // own program counter is a dummy target
      wr_en    = !((sel_level == current_level) &&
                   (dest_reg_field == ilrcs_pkg::REG_PC));
      wr_level = sel_level;
      wr_reg   = dest_reg_field;
      if (dest_reg_field == ilrcs_pkg::REG_STATUS) begin
        // only status bits 1-7 are replaced
        wr_data = (sel_val & ~ilrcs_pkg::STS_MASK) |
                  (bank_reg[current_level][ilrcs_pkg::REG_A] &
                   ilrcs_pkg::STS_MASK);
      end else begin
        wr_data = bank_reg[current_level][ilrcs_pkg::REG_A];
      end
    end else if (ext_wr_en && !is_read && !is_write) begin
      wr_en    = 1'b1;
      wr_level = ext_wr_level;
      wr_reg   = ext_wr_reg;
      wr_data  = ext_wr_data;
    end
  end

  genvar gl;
  genvar gr;
  generate
    for (gl = 0; gl < ilrcs_pkg::LEVELS; gl++) begin : g_lvl
      for (gr = 0; gr < ilrcs_pkg::NREGS; gr++) begin : g_reg
        always_ff @(posedge clock) begin
          if (!nrst) begin
            bank_reg[gl][gr] <= ilrcs_pkg::RESET_WORD;
          end else if (clk_en && wr_en && (wr_level == 4'(gl)) &&
                       (wr_reg == 3'(gr))) begin
            bank_reg[gl][gr] <= wr_data;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ext_rd_data <= ilrcs_pkg::RESET_WORD;
    end else if (clk_en) begin
      ext_rd_data <= bank_reg[ext_rd_level][ext_rd_reg];
    end
  end

  // result flags, registered one cycle after the instruction
  always_ff @(posedge clock) begin
    if (!nrst) begin
      interlevel_read_instr  <= 1'b0;
      interlevel_write_instr <= 1'b0;
      compare_skip_instr     <= 1'b0;
      skip_next              <= 1'b0;
      priv_violation         <= 1'b0;
      done                   <= 1'b0;
    end else if (clk_en) begin
      interlevel_read_instr  <= is_read;
      interlevel_write_instr <= is_write;
      compare_skip_instr     <= is_skip;
      skip_next              <= is_skip && cond_true;
      priv_violation         <= (is_read || is_write) && !privileged;
      done                   <= is_read || is_write || is_skip;
    end
  end
endmodule
`default_nettype wire

// File: sim/ilrcs_core_properties.sv
// ilrcs_chk: decode, privilege and skip relations on the core's ports.
// assumes it is bound to ilrcs_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ilrcs_chk (
  // clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // instruction side
  input wire logic        clk_en,
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic        privileged,
  // result flags
  input wire logic        interlevel_read_instr,
  input wire logic        interlevel_write_instr,
  input wire logic        compare_skip_instr,
  input wire logic        skip_next,
  input wire logic        priv_violation,
  input wire logic        done
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic tk, rd_op, wr_op, sk_op;
  assign tk = instr_valid && clk_en;
  assign rd_op = tk && (instr_word & ilrcs_pkg::READ_MASK) == ilrcs_pkg::READ_BASE;
  assign wr_op = tk && (instr_word & ilrcs_pkg::READ_MASK) == ilrcs_pkg::WRITE_BASE;
  assign sk_op = tk && (instr_word & ilrcs_pkg::SKIP_MASK) == ilrcs_pkg::SKIP_BASE;
  chk_read_decode: assert property (
    rd_op && privileged |=> interlevel_read_instr && done) else $error("read missed");
  chk_write_decode: assert property (
    wr_op && privileged |=> interlevel_write_instr && done) else $error("write missed");
  chk_skip_decode: assert property (
    sk_op |=> compare_skip_instr && done) else $error("compare missed");
  chk_ext_reject: assert property (
    tk && instr_word[15:11] == 5'h18 && instr_word[7:6] != 2'h0
    |=> !compare_skip_instr) else $error("extended word taken as compare");
  chk_priv_trap: assert property (
    (rd_op || wr_op) && !privileged |=> priv_violation) else $error("no trap");
  chk_priv_quiet: assert property (
    tk && privileged |=> !priv_violation) else $error("false trap");
  chk_skip_cause: assert property (
    skip_next |-> compare_skip_instr) else $error("skip without compare");
  chk_self_equal: assert property (
    sk_op && instr_word[5:3] == instr_word[2:0]
    |=> skip_next == !$past(instr_word[10])) else $error("zero difference");
endmodule
`default_nettype wire

// File: sim/ilrcs_core_bench.sv
// ilrcs_core_bench: directed tests of inter-level access and compare-skip.
// assumes the bank is reachable through the external read/write ports.
`timescale 1ns/1ps
`default_nettype none
module ilrcs_core_bench;
  logic        clock = 1'b0, nrst = 1'b0, clk_en = 1'b1, instr_valid = 1'b0;
  logic        privileged = 1'b1, ext_wr_en = 1'b0;
  logic [15:0] instr_word = 16'h0000, ext_wr_data = 16'h0000, ext_rd_data, v;
  logic [3:0]  current_level = 4'h1, ext_wr_level = 4'h0, ext_rd_level = 4'h0;
  logic [2:0]  ext_wr_reg = 3'h0, ext_rd_reg = 3'h0;
  logic        f_rd, f_wr, f_sk, f_skip, f_priv, f_done;
  logic [5:0]  fl;
  logic [15:0] pd [4] = '{16'h0005, 16'h8000, 16'h0001, 16'h0003};
  logic [15:0] ps [4] = '{16'h0005, 16'h0001, 16'h8000, 16'h0007};
  int          err_total = 0, checks = 0;
  always #20 clock = ~clock;
  ilrcs_core ilrcs_core_inst (.clock(clock), .nrst(nrst), .clk_en(clk_en),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .privileged(privileged), .current_level(current_level),
    .ext_wr_en(ext_wr_en), .ext_wr_level(ext_wr_level),
    .ext_wr_reg(ext_wr_reg), .ext_wr_data(ext_wr_data),
    .ext_rd_level(ext_rd_level), .ext_rd_reg(ext_rd_reg),
    .ext_rd_data(ext_rd_data), .interlevel_read_instr(f_rd),
    .interlevel_write_instr(f_wr), .compare_skip_instr(f_sk),
    .skip_next(f_skip), .priv_violation(f_priv), .done(f_done));
  task automatic check(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] l, input logic [2:0] r,
                    input logic [15:0] d);
    ext_wr_en = 1'b1;
    ext_wr_level = l;
    ext_wr_reg = r;
    ext_wr_data = d;
    @(negedge clock);
    ext_wr_en = 1'b0;
    @(negedge clock);
  endtask
  task automatic rd(input logic [3:0] l, input logic [2:0] r);
    ext_rd_level = l;
    ext_rd_reg = r;
    @(negedge clock);
    v = ext_rd_data;
  endtask
  // flags captured on the falling edge half a cycle after the word is taken
  task automatic exec(input logic [15:0] w, input logic p);
    instr_valid = 1'b1;
    instr_word = w;
    privileged = p;
    @(negedge clock);
    fl = {f_rd, f_wr, f_sk, f_skip, f_priv, f_done};
    instr_valid = 1'b0;
    @(negedge clock);
  endtask
  function automatic logic cond_ok(input logic [15:0] d, s, input int c);
    logic [16:0] r;
    logic        o;
    r = {1'b0, d} - {1'b0, s};
    o = (d[15] != s[15]) && (r[15] != d[15]);
    case (c[1:0])
      2'h0: cond_ok = (r[15:0] == 16'h0000);
      2'h1: cond_ok = !r[15];
      2'h2: cond_ok = !(r[15] ^ o);
      default: cond_ok = !r[16];
    endcase
    if (c[2]) cond_ok = !cond_ok;
  endfunction
  initial begin
    #120000;
    err_total++;
    finish_test();
  end
  initial begin
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    wr(4'h1, 3'h5, 16'hABCD);
    wr(4'h3, 3'h2, 16'h1234);
    wr(4'h4, 3'h0, 16'hFFFF);
    wr(4'h7, 3'h0, 16'hFF01);
    wr(4'h1, 3'h2, 16'h5555);
    exec(16'hD79A, 1'b1);
    check("read flags", {10'h000, fl}, 16'h0021);
    rd(4'h1, 3'h5);
    check("read value", v, 16'h1234);
    exec(16'hD7A0, 1'b1);
    rd(4'h1, 3'h5);
    check("status read", v, 16'h00FE);
    wr(4'h1, 3'h5, 16'hABCD);
    exec(16'hD71B, 1'b1);
    check("write flags", {10'h000, fl}, 16'h0011);
    rd(4'h3, 3'h3);
    check("write value", v, 16'hABCD);
    exec(16'hD738, 1'b1);
    rd(4'h7, 3'h0);
    check("status write", v, 16'hFFCD);
    exec(16'hD70A, 1'b1);
    rd(4'h1, 3'h2);
    check("own pc write", v, 16'h5555);
    exec(16'hD71A, 1'b0);
    check("write trap", {15'h0000, fl[1]}, 16'h0001);
    rd(4'h3, 3'h2);
    check("trap no write", v, 16'h1234);
    exec(16'hD79A, 1'b0);
    rd(4'h1, 3'h5);
    check("trap no read", v, 16'hABCD);
    exec(16'hC040, 1'b1);
    check("extended word", {15'h0000, fl[3]}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(4'h1, 3'h5, pd[i]);
      wr(4'h1, 3'h2, ps[i]);
      for (int c = 0; c < 8; c++) begin
        exec(16'hC000 | (16'(c) << 8) | (i == 0 ? 16'h002D : 16'h0015), 1'b1);
        check("skip", {14'h0000, fl[3:2]}, {14'h0001, cond_ok(pd[i], ps[i], c)});
      end
    end
    finish_test();
  end
endmodule
bind ilrcs_core ilrcs_chk ilrcs_chk_inst (.clock(clock), .nrst(nrst),
  .clk_en(clk_en), .instr_valid(instr_valid), .instr_word(instr_word),
  .privileged(privileged), .interlevel_read_instr(interlevel_read_instr),
  .interlevel_write_instr(interlevel_write_instr),
  .compare_skip_instr(compare_skip_instr), .skip_next(skip_next),
  .priv_violation(priv_violation), .done(done));
`default_nettype wire
